// >>> test/psi_irq_sink.sv
// Interrupt controller model counting pulses per line
`timescale 1ns/100ps
`default_nettype none
module psi_irq_sink #(
	parameter int NLINE = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NLINE-1:0] irq_line,
	output logic [NLINE-1:0][7:0] pulse_cnt
);
	// Counts cycles high, so a stuck line shows as extra pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt <= '0;
		end else begin
			for (int i = 0; i < NLINE; i++) begin
				if (irq_line[i]) pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
			end
		end
	end
endmodule : psi_irq_sink
`default_nettype wire

// >>> test/psi_monitor.sv
// Checker of bus answers, pin levels and interrupt causes
`timescale 1ns/100ps
`default_nettype none
`include "psi_defs.svh"
module psi_monitor #(
	parameter int NLINE = `PSI_NLINE
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire psi_pkg::psi_evt_t events,
	input wire psi_pkg::psi_sync_t sync,
	input wire logic trap_input,
	input wire logic [5:0] first_timer_active,
	input wire logic second_timer_active,
	input wire logic [5:0] multichannel_pattern_in,
	input wire logic [5:0] first_timer_out,
	input wire logic second_timer_output,
	input wire logic [5:0] multichannel_pattern,
	input wire logic [NLINE-1:0] irq_line
);
	logic [7:0] shd_r;
	logic [7:0] act_r;
	wire take = psel && penable && !pready;
	// Mirror of the level shadow; valid only while trap and idle forcing stay off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shd_r <= 8'h00;
			act_r <= 8'h00;
		end else begin
			if (take && pwrite && paddr[15:0] == `PSI_OFS_PASSIVE) shd_r <= pwdata[7:0] & 8'hBF;
			if (sync.t1_shadow_xfer) act_r <= shd_r;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_lvl1;
		$past(presetn) && $past(presetn, 2) |->
			first_timer_out == ($past(act_r[5:0]) ^ $past(first_timer_active));
	endproperty
	a_lvl1: assert property (p_lvl1) else $error("first timer pin level wrong");
	property p_lvl2;
		$past(presetn) && $past(presetn, 2) |->
			second_timer_output == ($past(act_r[7]) ^ $past(second_timer_active));
	endproperty
	a_lvl2: assert property (p_lvl2) else $error("second timer pin level wrong");
	property p_irq_cause;
		|irq_line |-> $past(|events || (take && pwrite));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
	property p_setclr_zero;
		pready && !pwrite && (paddr[15:0] == `PSI_OFS_SET || paddr[15:0] == `PSI_OFS_CLEAR)
			|-> prdata == 32'h0000_0000;
	endproperty
	a_setclr_zero: assert property (p_setclr_zero) else $error("set or clear read not zero");
	property p_pattern;
		multichannel_pattern != 6'h00 |-> multichannel_pattern == $past(multichannel_pattern_in);
	endproperty
	a_pattern: assert property (p_pattern) else $error("pattern not passed through");
	property p_answer;
		take |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no bus answer");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	c_irq: cover property (|irq_line);
	c_xfer: cover property (sync.t1_shadow_xfer);
	c_err: cover property (pslverr);
endmodule : psi_monitor
bind psi_status_irq psi_monitor #(.NLINE(NLINE)) u_mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .events, .sync, .trap_input,
	.first_timer_active, .second_timer_active, .multichannel_pattern_in, .first_timer_out,
	.second_timer_output, .multichannel_pattern, .irq_line);
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench of the status, interrupt and passive-level block
`timescale 1ns/100ps
`default_nettype none
`include "psi_defs.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trap_input, sta, sto, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [5:0] fta, fto, mpi, mpo;
	logic [3:0] irq;
	logic [3:0][7:0] cnt;
	psi_pkg::psi_evt_t events;
	psi_pkg::psi_sync_t sync;
	int err_count, total_checks, cyc;
	psi_status_irq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .events, .sync, .trap_input, .first_timer_active(fta),
		.second_timer_active(sta), .multichannel_pattern_in(mpi), .first_timer_out(fto),
		.second_timer_output(sto), .multichannel_pattern(mpo), .irq_line(irq));
	psi_irq_sink sink (.pclk, .presetn, .irq_line(irq), .pulse_cnt(cnt));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {16'h0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic evt(psi_pkg::psi_evt_t e);
		@(posedge pclk);
		events <= e;
		@(posedge pclk);
		events <= '0;
		#1;
	endtask : evt
	task automatic t_regs();
		apb(1'b0, `PSI_OFS_PASSIVE, 32'h0);
		chk("passive rst", rd, `PSI_RST_WORD);
		apb(1'b0, 16'hE8F0, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, `PSI_OFS_SET, 32'h0000_0300);
		apb(1'b1, `PSI_OFS_STATUS, 32'h0);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("status ro", rd, 32'h0000_0300);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_0100);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("clear one", rd, 32'h0000_0200);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_7FFF);
	endtask : t_regs
	task automatic t_passive();
		apb(1'b1, `PSI_OFS_PASSIVE, 32'h0000_00FF);
		apb(1'b0, `PSI_OFS_PASSIVE, 32'h0);
		chk("shadow hidden", rd, 32'h0);
		sync <= 3'b100;
		fta <= 6'h2A;
		sta <= 1'b1;
		@(posedge pclk);
		sync <= 3'b000;
		apb(1'b0, `PSI_OFS_PASSIVE, 32'h0);
		chk("passive used", rd, 32'h0000_00BF);
		chk("t1 active", {26'h0, fto}, 32'h15);
		chk("t2 active", {31'h0, sto}, 32'h0);
		fta <= 6'h00;
		sta <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk("t1 passive", {26'h0, fto}, 32'h3F);
		chk("t2 passive", {31'h0, sto}, 32'h1);
	endtask : t_passive
	task automatic t_irq();
		apb(1'b1, `PSI_OFS_ENABLE, 32'h0000_03C1);
		apb(1'b1, `PSI_OFS_NODE_LO, 32'h0000_4000);
		apb(1'b1, `PSI_OFS_NODE_HI, 32'h0000_000E);
		for (int i = 0; i < 4; i++) begin
			evt(12'h020 >> i);
			chk("irq line", {28'h0, irq}, 32'h1 << i);
			@(posedge pclk);
			#1;
			chk("irq end", {28'h0, irq}, 32'h0);
		end
		evt(12'h004);
		chk("irq again", {28'h0, irq}, 32'h8);
		evt(12'h060);
		chk("irq shared", {28'h0, irq}, 32'h1);
		evt(12'h003);
		chk("irq off", {28'h0, irq}, 32'h0);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("flags", rd, 32'h0000_33C1);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_7FFF);
		apb(1'b1, `PSI_OFS_SET, 32'h0000_0200);
		@(posedge pclk);
		#1;
		chk("soft irq", {24'h0, cnt[3]}, 32'h3);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_7FFF);
	endtask : t_irq
	task automatic t_trap(logic [31:0] mode, logic [31:0] after);
		apb(1'b1, `PSI_OFS_TRAP_CTRL, mode);
		trap_input <= 1'b0;
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("trap on", {30'h0, rd[11:10]}, 32'h3);
		trap_input <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("trap exit", {30'h0, rd[11:10]}, after);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_0400);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("trap clear", {30'h0, rd[11:10]}, 32'h0);
	endtask : t_trap
	task automatic t_idle();
		apb(1'b1, `PSI_OFS_HALL_CTRL, 32'h1);
		mpi <= 6'h2D;
		evt(12'h001);
		apb(1'b0, `PSI_OFS_STATUS, 32'h0);
		chk("idle set", {30'h0, rd[14:13]}, 32'h3);
		chk("idle pattern", {26'h0, mpo}, 32'h0);
		apb(1'b1, `PSI_OFS_CLEAR, 32'h0000_4000);
		repeat (2) @(posedge pclk);
		#1;
		chk("pattern back", {26'h0, mpo}, 32'h2D);
	endtask : t_idle
	initial begin
		{presetn, psel, penable, pwrite, trap_input, sta} = 6'h08;
		{paddr, pwdata, fta, mpi} = '0;
		events = '0;
		sync = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_passive();
		t_irq();
		t_trap(32'h0000_8003, 32'h0);
		t_trap(32'h0000_8007, 32'h3);
		t_idle();
		complete_run();
	end
endmodule : testbench
`default_nettype wire

// >>> verilog/psi_defs.svh
// Register offsets, field positions, reset values and widths of the status and passive-level block
`ifndef PSI_DEFS_SVH
`define PSI_DEFS_SVH
`define PSI_OFS_PASSIVE 16'hE8C4
`define PSI_OFS_STATUS 16'hE8D0
`define PSI_OFS_SET 16'hE8D2
`define PSI_OFS_CLEAR 16'hE8D4
`define PSI_OFS_ENABLE 16'hE8D8
`define PSI_OFS_NODE_LO 16'hE8DC
`define PSI_OFS_NODE_HI 16'hE8E0
`define PSI_OFS_TRAP_CTRL 16'hE8E4
`define PSI_OFS_HALL_CTRL 16'hE8E8
`define PSI_OFS_OUT_CTRL 16'hE8EC
`define PSI_ADDR_W 16
`define PSI_NSRC 15
`define PSI_NLINE 4
`define PSI_RST_PASSIVE 16'h0000
`define PSI_RST_STATUS 16'h0000
`define PSI_RST_WORD 32'h0000_0000
`define PSI_BIT_IDLE 14
`define PSI_BIT_WHE 13
`define PSI_BIT_CHE 12
`define PSI_BIT_TSTATE 11
`define PSI_BIT_TFLAG 10
`define PSI_BIT_T2PM 9
`define PSI_BIT_T2CM 8
`define PSI_BIT_T1PM 7
`define PSI_BIT_T1OM 6
`define PSI_BIT_T2PSL 7
`define PSI_MSK_FLAGS 16'h77FF
`define PSI_MSK_PASSIVE 16'h00BF
`define PSI_TC_PINEN 15
`define PSI_TC_EXIT 2
`define PSI_TC_SYNC 1:0
`define PSI_HC_IDLE_EN 0
`define PSI_OC_TRAP_T2 6
`define PSI_OC_IDLE_BASE 8
`define PSI_SYNC_T1 2'h0
`define PSI_SYNC_T2 2'h1
`define PSI_SYNC_NONE 2'h3
`endif

// >>> verilog/psi_pkg.sv
// Types shared by the status and passive-level block
package psi_pkg;
	typedef enum logic [1:0] {
		PSI_TRAP_OFF = 2'h0,
		PSI_TRAP_ON = 2'h1,
		PSI_TRAP_LEAVE = 2'h3
	} psi_trap_t;
	typedef struct packed {
		logic [5:0] cap_cmp;
		logic t1_one_match;
		logic t1_period;
		logic t2_compare;
		logic t2_period;
		logic hall_correct;
		logic hall_wrong;
	} psi_evt_t;
	typedef struct packed {
		logic t1_shadow_xfer;
		logic t1_zero;
		logic t2_zero;
	} psi_sync_t;
endpackage : psi_pkg

// >>> verilog/psi_status_irq.sv
// Interrupt status flags, interrupt routing and output passive-level logic
// Operation
// - Active outputs drive inverted passive level; passive outputs drive the level.
// - Bit 7 of passive-level register sets second timer output level.
// - Bits 5..0 set first timer output levels, ch2 comp down to ch0.
// - Period parameters kept in shadow copies, taken together per period.
// - Interrupt triggered by hardware event or software set write.
// - Interrupt pulse made regardless of flag already being set.
// - Software clears any flag except trap state (bit 11) via flag-clear register.
// - Pulse only when enabled; routed to one of four lines.
// - Sources sharing a line are ORed onto it.
// - Status register read-only; writes leave it unchanged.
// - With idle enable, idle flag sets with wrong-hall flag; software clears.
// - While idle, pattern cleared and selected outputs forced passive.
// - Bit 13 set on change to an unexpected hall pattern.
// - Bit 12 set on change to the expected hall pattern.
// - Trap state follows trap flag; cleared per synchronisation mode.
// - Trap flag set by low enabled trap input or software.
// - Exit mode 0 hardware clears flag on high input; mode 1 software.
// - Bit 9 on second timer period match, bit 8 on compare match.
// - Bit 7 on first timer period match counting up.
// - Bit 6 on first timer one-match counting down.
// - Set/clear writes of 1 act, 0 ignored; both read zero.
// - Passive-level reads return active bits; writes go to shadow.
// - Bits 5..0 flag compare matches or capture edges per channel.
`timescale 1ns/100ps
`default_nettype none
`include "psi_defs.svh"
module psi_status_irq #(
	parameter int NLINE = `PSI_NLINE
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire psi_pkg::psi_evt_t events,
	input wire psi_pkg::psi_sync_t sync,
	input wire logic trap_input,
	input wire logic [5:0] first_timer_active,
	input wire logic second_timer_active,
	input wire logic [5:0] multichannel_pattern_in,
	output logic [5:0] first_timer_out,
	output logic second_timer_output,
	output logic [5:0] multichannel_pattern,
	output logic [NLINE-1:0] irq_line
);
	logic [15:0] passive_shadow_r;
	logic [15:0] passive_active_r;
	logic [15:0] flags_r;
	logic [15:0] enable_r;
	logic [31:0] node_r;
	logic [15:0] trap_ctrl_r;
	logic [15:0] hall_ctrl_r;
	logic [15:0] out_ctrl_r;
	psi_pkg::psi_trap_t trap_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [5:0] t1_out_r;
	logic t2_out_r;
	logic [5:0] pattern_r;
	logic [NLINE-1:0] irq_r;
	logic wr_acc;
	logic rd_acc;
	logic [15:0] off;
	logic [15:0] set_w;
	logic [15:0] clr_w;
	logic [15:0] hw_set;
	logic [15:0] trig;
	logic trap_hw_clr;
	logic trap_state_set;
	logic mapped;

	// Uniform sixteen-bit write value used by several registers
	function automatic logic [15:0] lo16(input logic [31:0] d);
		return d[15:0];
	endfunction : lo16

	// Node pointer of one source: two bits per source
	function automatic logic [1:0] node_of(input logic [31:0] n, input int s);
		return n[2*s +: 2];
	endfunction : node_of

	assign wr_acc = psel && penable && pwrite && !pready_r;
	assign rd_acc = psel && penable && !pwrite && !pready_r;
	assign off = paddr[15:0];
	assign mapped = (off == `PSI_OFS_PASSIVE) || (off == `PSI_OFS_STATUS)
		|| (off == `PSI_OFS_SET) || (off == `PSI_OFS_CLEAR)
		|| (off == `PSI_OFS_ENABLE) || (off == `PSI_OFS_NODE_LO)
		|| (off == `PSI_OFS_NODE_HI) || (off == `PSI_OFS_TRAP_CTRL)
		|| (off == `PSI_OFS_HALL_CTRL) || (off == `PSI_OFS_OUT_CTRL);

	// Writes of 1 act, 0 ignored, trap state bit not settable
	assign set_w = (wr_acc && off == `PSI_OFS_SET) ?
		(lo16(pwdata) & `PSI_MSK_FLAGS) : 16'h0000;
	assign clr_w = (wr_acc && off == `PSI_OFS_CLEAR) ?
		(lo16(pwdata) & `PSI_MSK_FLAGS) : 16'h0000;

	always_comb begin
		hw_set = 16'h0000;
		hw_set[5:0] = events.cap_cmp;
		hw_set[`PSI_BIT_T1OM] = events.t1_one_match;
		hw_set[`PSI_BIT_T1PM] = events.t1_period;
		hw_set[`PSI_BIT_T2CM] = events.t2_compare;
		hw_set[`PSI_BIT_T2PM] = events.t2_period;
		hw_set[`PSI_BIT_CHE] = events.hall_correct;
		hw_set[`PSI_BIT_WHE] = events.hall_wrong;
		hw_set[`PSI_BIT_IDLE] = events.hall_wrong && hall_ctrl_r[`PSI_HC_IDLE_EN];
		hw_set[`PSI_BIT_TFLAG] = trap_ctrl_r[`PSI_TC_PINEN] && !trap_input;
	end

	// Exit mode 0 with enabled pin: flag drops once input is high again
	assign trap_hw_clr = !trap_ctrl_r[`PSI_TC_EXIT] && trap_ctrl_r[`PSI_TC_PINEN]
		&& trap_input;
	assign trig = hw_set | set_w;

	// Set wins over clear so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= `PSI_RST_STATUS;
		end else begin
			for (int b = 0; b < 16; b++) begin
				if (b == `PSI_BIT_TSTATE) begin
					flags_r[b] <= (trap_r != psi_pkg::PSI_TRAP_OFF);
				end else if (trig[b]) begin
					flags_r[b] <= 1'b1;
				end else if (clr_w[b]) begin
					flags_r[b] <= 1'b0;
				end else if (b == `PSI_BIT_TFLAG && trap_hw_clr) begin
					flags_r[b] <= 1'b0;
				end
			end
		end
	end

	assign trap_state_set = trig[`PSI_BIT_TFLAG] || flags_r[`PSI_BIT_TFLAG];

	// Trap state held until flag drops and the chosen sync edge arrives; with no sync it leaves two cycles after the flag drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_r <= psi_pkg::PSI_TRAP_OFF;
		end else begin
			case (trap_r)
				psi_pkg::PSI_TRAP_OFF: begin
					if (trap_state_set) begin
						trap_r <= psi_pkg::PSI_TRAP_ON;
					end
				end
				psi_pkg::PSI_TRAP_ON: begin
					if (!trap_state_set) begin
						trap_r <= psi_pkg::PSI_TRAP_LEAVE;
					end
				end
				psi_pkg::PSI_TRAP_LEAVE: begin
					if (trap_state_set) begin
						trap_r <= psi_pkg::PSI_TRAP_ON;
					end else begin
						case (trap_ctrl_r[`PSI_TC_SYNC])
							`PSI_SYNC_T1: if (sync.t1_zero) trap_r <= psi_pkg::PSI_TRAP_OFF;
							`PSI_SYNC_T2: if (sync.t2_zero) trap_r <= psi_pkg::PSI_TRAP_OFF;
							`PSI_SYNC_NONE: trap_r <= psi_pkg::PSI_TRAP_OFF;
							default: trap_r <= psi_pkg::PSI_TRAP_LEAVE;
						endcase
					end
				end
				default: trap_r <= psi_pkg::PSI_TRAP_OFF;
			endcase
		end
	end

	// Control registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= `PSI_RST_STATUS;
			node_r <= `PSI_RST_WORD;
			trap_ctrl_r <= `PSI_RST_STATUS;
			hall_ctrl_r <= `PSI_RST_STATUS;
			out_ctrl_r <= `PSI_RST_STATUS;
		end else if (wr_acc) begin
			case (off)
				`PSI_OFS_ENABLE: enable_r <= lo16(pwdata) & `PSI_MSK_FLAGS;
				`PSI_OFS_NODE_LO: node_r[15:0] <= lo16(pwdata);
				`PSI_OFS_NODE_HI: node_r[31:16] <= lo16(pwdata);
				`PSI_OFS_TRAP_CTRL: trap_ctrl_r <= lo16(pwdata);
				`PSI_OFS_HALL_CTRL: hall_ctrl_r <= lo16(pwdata);
				`PSI_OFS_OUT_CTRL: out_ctrl_r <= lo16(pwdata);
				default: enable_r <= enable_r;
			endcase
		end
	end

	// Writes land in shadow, in-use bits move on shadow transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			passive_shadow_r <= `PSI_RST_PASSIVE;
			passive_active_r <= `PSI_RST_PASSIVE;
		end else begin
			if (wr_acc && off == `PSI_OFS_PASSIVE) begin
				passive_shadow_r <= lo16(pwdata) & `PSI_MSK_PASSIVE;
			end
			if (sync.t1_shadow_xfer) begin
				passive_active_r <= passive_shadow_r;
			end
		end
	end

	// Pulse on every enabled trigger, independent of flag; OR per line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= '0;
		end else begin
			for (int l = 0; l < NLINE; l++) begin
				logic hit;
				hit = 1'b0;
				for (int s = 0; s < 16; s++) begin
					if (trig[s] && enable_r[s] && node_of(node_r, s) == 2'(l)) begin
						hit = 1'b1;
					end
				end
				irq_r[l] <= hit;
			end
		end
	end

	// Outputs: trap and idle force enabled outputs passive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t1_out_r <= 6'h00;
			t2_out_r <= 1'b0;
			pattern_r <= 6'h00;
		end else begin
			for (int c = 0; c < 6; c++) begin
				logic act;
				act = first_timer_active[c];
				if (trap_r != psi_pkg::PSI_TRAP_OFF && out_ctrl_r[c]) act = 1'b0;
				if (flags_r[`PSI_BIT_IDLE] && out_ctrl_r[`PSI_OC_IDLE_BASE+c]) act = 1'b0;
				t1_out_r[c] <= passive_active_r[c] ^ act;
			end
			t2_out_r <= passive_active_r[`PSI_BIT_T2PSL] ^ (second_timer_active
				&& !(trap_r != psi_pkg::PSI_TRAP_OFF && out_ctrl_r[`PSI_OC_TRAP_T2]));
			pattern_r <= flags_r[`PSI_BIT_IDLE] ? 6'h00 : multichannel_pattern_in;
		end
	end

	// APB: one wait state, reads sample registers, unmapped gives error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= `PSI_RST_WORD;
		end else begin
			pready_r <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !mapped;
			if (rd_acc) begin
				case (off)
					`PSI_OFS_PASSIVE: prdata_r <= {16'h0000, passive_active_r};
					`PSI_OFS_STATUS: prdata_r <= {16'h0000, flags_r};
					`PSI_OFS_ENABLE: prdata_r <= {16'h0000, enable_r};
					`PSI_OFS_NODE_LO: prdata_r <= {16'h0000, node_r[15:0]};
					`PSI_OFS_NODE_HI: prdata_r <= {16'h0000, node_r[31:16]};
					`PSI_OFS_TRAP_CTRL: prdata_r <= {16'h0000, trap_ctrl_r};
					`PSI_OFS_HALL_CTRL: prdata_r <= {16'h0000, hall_ctrl_r};
					`PSI_OFS_OUT_CTRL: prdata_r <= {16'h0000, out_ctrl_r};
					default: prdata_r <= `PSI_RST_WORD;
				endcase
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign first_timer_out = t1_out_r;
	assign second_timer_output = t2_out_r;
	assign multichannel_pattern = pattern_r;
	assign irq_line = irq_r;
endmodule : psi_status_irq
`default_nettype wire
